// ---- supmon_map.svh ----
`ifndef SUPMON_MAP_SVH
`define SUPMON_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SUPMON_ADDR_STATUS      8'h07
`define SUPMON_ADDR_CONTROL     8'h08
`define SUPMON_ADDR_BROWNOUT    8'h09
`define SUPMON_ADDR_BATTERY     8'h0a
`define SUPMON_ADDR_TRIM        8'h0b
`define SUPMON_ADDR_TEMPCTL     8'h0d

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SUPMON_STAT_LOW_SUPPLY  3
`define SUPMON_STAT_BAT_FIRST   2
`define SUPMON_STAT_BAT_SECOND  1
`define SUPMON_CTRL_AUTO_CLEAR  7
`define SUPMON_BAT_DISCONNECT   6
`define SUPMON_BAT_FIRST_LSB    3
`define SUPMON_BAT_SECOND_LSB   0
`define SUPMON_TRIM_DIG_LSB     6
`define SUPMON_TEMPCTL_SENSE    7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SUPMON_RST_SEL          3'h0
`define SUPMON_RST_BYTE         8'h00
`define SUPMON_ATRIM_ZERO       7'h20

// ----------------------------------------------------------------------------
// Trip levels in millivolts
// ----------------------------------------------------------------------------
`define SUPMON_MV_1875          13'd1875
`define SUPMON_MV_2025          13'd2025
`define SUPMON_MV_2125          13'd2125
`define SUPMON_MV_2250          13'd2250
`define SUPMON_MV_2295          13'd2295
`define SUPMON_MV_2475          13'd2475
`define SUPMON_MV_2550          13'd2550
`define SUPMON_MV_2700          13'd2700
`define SUPMON_MV_2805          13'd2805
`define SUPMON_MV_3060          13'd3060
`define SUPMON_MV_3750          13'd3750
`define SUPMON_MV_4125          13'd4125
`define SUPMON_MV_4250          13'd4250
`define SUPMON_MV_4675          13'd4675
`define SUPMON_MV_NONE          13'd0
`define SUPMON_MV_WIDTH         13

`endif

// ---- supmon_pkg.sv ----
package supmon_pkg;

    typedef enum logic [1:0] {
        DTRIM_OFF,
        DTRIM_PLUS,
        DTRIM_ZERO,
        DTRIM_MINUS
    } supmon_dtrim_type;

    typedef logic [7:0] supmon_byte_type;

endpackage : supmon_pkg

// ---- supmon_flag.sv ----
`timescale 1ns/10ps
module supmon_flag (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic raw_below,
    input  wire logic clear,
    output logic      level_sync,
    output logic      flag
);
    logic meta_q;
    logic sync_q;
    logic flag_q;

    // ------------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_below;
            sync_q <= meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Sticky flag
    // ------------------------------------------------------------------------
    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else if (sync_q) begin
            flag_q <= 1'b1;
        end else if (clear) begin
            flag_q <= 1'b0;
        end
    end

    assign level_sync = sync_q;
    assign flag       = flag_q;

endmodule : supmon_flag

// ---- supmon_regs.sv ----
// Functional notes
// RULE_01 - Primary supply below brownout level sets the low-supply flag.
// RULE_02 - Brownout selector codes 0-3 low levels, codes 4-5 two highest.
// RULE_03 - Battery register at 0Ah: disconnect bit6, first sel 5:3, second 2:0.
// RULE_04 - Writing one to disconnect bit starts backup battery isolation.
// RULE_05 - Primary supply power-up clears disconnect bit and reconnects battery.
// RULE_06 - First battery selector: seven rising levels on codes 0 to 6.
// RULE_07 - Second battery selector: seven rising levels on codes 0 to 6.
// RULE_08 - Trim register at 0Bh: digital trim 7:6, analog trim 5:0.
// RULE_09 - Trim preset loaded at power-up; software writes leave it unchanged.
// RULE_10 - Digital trim skips or inserts pulses; analog trim changes load capacitance.
// RULE_11 - Digital code: 00 off, 01 plus step, 10 zero, 11 minus step.
// RULE_12 - Software changes digital trim only while temperature sensing is off; writes to 0Bh are ignored, the preset load waits for sensing off.
// RULE_13 - Analog trim 1ppm per step, code 0 is +32 down to -31.
// RULE_14 - Battery below first selected level sets first low-battery flag.
// RULE_15 - Battery below second selected level sets second low-battery flag.
// RULE_16 - With auto clear, status read ending in STOP clears the three flags.
// RULE_17 - Brownout selector sits in the three low bits at 09h.
// RULE_18 - Flags set from synchronised comparators and stay set until cleared.
`timescale 1ns/10ps
`include "supmon_map.svh"
module supmon_regs #(
    parameter int MV_W = `SUPMON_MV_WIDTH
) (
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic [7:0]               reg_addr,
    input  wire supmon_pkg::supmon_byte_type reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic                     bus_stop,
    output supmon_pkg::supmon_byte_type   reg_rdata,
    input  wire logic [7:0]               factory_trim,
    input  wire logic                     vdd_power_up,
    input  wire logic                     supply_below,
    input  wire logic                     bat_first_below,
    input  wire logic                     bat_second_below,
    output logic [MV_W-1:0]               brownout_thresh_mv,
    output logic [MV_W-1:0]               bat_first_thresh_mv,
    output logic [MV_W-1:0]               bat_second_thresh_mv,
    output logic                          battery_isolate,
    output logic                          low_supply_flag,
    output logic                          battery_first_low_flag,
    output logic                          battery_second_low_flag,
    output logic                          temp_sense_enable,
    output supmon_pkg::supmon_dtrim_type  digital_trim_mode,
    output logic                          pulse_insert_en,
    output logic                          pulse_skip_en,
    output logic [5:0]                    load_cap_code,
    output logic signed [6:0]             analog_trim_ppm
);
    import supmon_pkg::*;

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (MV_W != `SUPMON_MV_WIDTH) begin : g_width_check
        $error("supmon_regs: MV_W must equal the millivolt field width");
    end

    // ------------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------------
    function automatic logic [MV_W-1:0] brownout_mv(input logic [2:0] sel);
        unique case (sel)
            3'h0:    brownout_mv = `SUPMON_MV_2295;
            3'h1:    brownout_mv = `SUPMON_MV_2550;
            3'h2:    brownout_mv = `SUPMON_MV_2805;
            3'h3:    brownout_mv = `SUPMON_MV_3060;
            3'h4:    brownout_mv = `SUPMON_MV_4250;
            3'h5:    brownout_mv = `SUPMON_MV_4675;
            default: brownout_mv = `SUPMON_MV_NONE;
        endcase
    endfunction : brownout_mv

    function automatic logic [MV_W-1:0] bat_first_mv(input logic [2:0] sel);
        unique case (sel)
            3'h0:    bat_first_mv = `SUPMON_MV_2125;
            3'h1:    bat_first_mv = `SUPMON_MV_2295;
            3'h2:    bat_first_mv = `SUPMON_MV_2550;
            3'h3:    bat_first_mv = `SUPMON_MV_2805;
            3'h4:    bat_first_mv = `SUPMON_MV_3060;
            3'h5:    bat_first_mv = `SUPMON_MV_4250;
            3'h6:    bat_first_mv = `SUPMON_MV_4675;
            default: bat_first_mv = `SUPMON_MV_NONE;
        endcase
    endfunction : bat_first_mv

    function automatic logic [MV_W-1:0] bat_second_mv(input logic [2:0] sel);
        unique case (sel)
            3'h0:    bat_second_mv = `SUPMON_MV_1875;
            3'h1:    bat_second_mv = `SUPMON_MV_2025;
            3'h2:    bat_second_mv = `SUPMON_MV_2250;
            3'h3:    bat_second_mv = `SUPMON_MV_2475;
            3'h4:    bat_second_mv = `SUPMON_MV_2700;
            3'h5:    bat_second_mv = `SUPMON_MV_3750;
            3'h6:    bat_second_mv = `SUPMON_MV_4125;
            default: bat_second_mv = `SUPMON_MV_NONE;
        endcase
    endfunction : bat_second_mv

    // ------------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------------
    logic [2:0]       brownout_level_sel_q;
    logic [2:0]       battery_first_level_sel_q;
    logic [2:0]       battery_second_level_sel_q;
    logic             battery_disconnect_q;
    logic             auto_clear_enable_q;
    logic             temp_sense_enable_q;
    logic [7:0]       trim_q;
    logic             trim_loaded_q;
    logic             status_rd_q;
    supmon_byte_type  rdata_q;
    logic             wr_status;
    logic             auto_clear;
    logic             supply_sync;
    logic             bat_first_sync;
    logic             bat_second_sync;
    logic [1:0]       digital_trim_code;
    logic [5:0]       analog_trim_code;

    assign wr_status         = reg_wr && (reg_addr == `SUPMON_ADDR_STATUS);
    assign digital_trim_code = trim_q[7:`SUPMON_TRIM_DIG_LSB];               // RULE_08
    assign analog_trim_code  = trim_q[`SUPMON_TRIM_DIG_LSB-1:0];             // RULE_08

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            brownout_level_sel_q <= `SUPMON_RST_SEL;
        end else if (reg_wr && reg_addr == `SUPMON_ADDR_BROWNOUT) begin
            brownout_level_sel_q <= reg_wdata[2:0];                          // RULE_17
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            battery_first_level_sel_q  <= `SUPMON_RST_SEL;
            battery_second_level_sel_q <= `SUPMON_RST_SEL;
        end else if (reg_wr && reg_addr == `SUPMON_ADDR_BATTERY) begin
            battery_first_level_sel_q  <= reg_wdata[`SUPMON_BAT_FIRST_LSB+:3];  // RULE_03
            battery_second_level_sel_q <= reg_wdata[`SUPMON_BAT_SECOND_LSB+:3]; // RULE_03
        end
    end

    // Power-up of the primary supply outranks a coincident write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            battery_disconnect_q <= 1'b0;
        end else if (vdd_power_up) begin
            battery_disconnect_q <= 1'b0;                                    // RULE_05
        end else if (reg_wr && reg_addr == `SUPMON_ADDR_BATTERY) begin
            battery_disconnect_q <= reg_wdata[`SUPMON_BAT_DISCONNECT];       // RULE_04
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            auto_clear_enable_q <= 1'b0;
        end else if (reg_wr && reg_addr == `SUPMON_ADDR_CONTROL) begin
            auto_clear_enable_q <= reg_wdata[`SUPMON_CTRL_AUTO_CLEAR];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            temp_sense_enable_q <= 1'b0;
        end else if (reg_wr && reg_addr == `SUPMON_ADDR_TEMPCTL) begin
            temp_sense_enable_q <= reg_wdata[`SUPMON_TEMPCTL_SENSE];
        end
    end

    // ------------------------------------------------------------------------
    // Trim recall
    // ------------------------------------------------------------------------
    // Preset is sampled after reset release, never under reset; no write path
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            trim_q        <= `SUPMON_RST_BYTE;
            trim_loaded_q <= 1'b0;
        end else if (!trim_loaded_q && !temp_sense_enable_q) begin
            trim_q        <= factory_trim;                                   // RULE_09 RULE_12
            trim_loaded_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            digital_trim_mode <= DTRIM_OFF;
            pulse_insert_en   <= 1'b0;
            pulse_skip_en     <= 1'b0;
        end else begin
            unique case (digital_trim_code)                                  // RULE_11
                2'h0: digital_trim_mode <= DTRIM_OFF;
                2'h1: digital_trim_mode <= DTRIM_PLUS;
                2'h2: digital_trim_mode <= DTRIM_ZERO;
                2'h3: digital_trim_mode <= DTRIM_MINUS;
            endcase
            // Speeding up inserts pulses, slowing down skips them
            pulse_insert_en <= (digital_trim_code == 2'h1);                  // RULE_10
            pulse_skip_en   <= (digital_trim_code == 2'h3);                  // RULE_10
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            load_cap_code   <= 6'h00;
            analog_trim_ppm <= 7'sh00;
        end else begin
            load_cap_code   <= analog_trim_code;                             // RULE_10
            analog_trim_ppm <= signed'(`SUPMON_ATRIM_ZERO - {1'b0, analog_trim_code}); // RULE_13
        end
    end

    // ------------------------------------------------------------------------
    // Trip level outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            brownout_thresh_mv   <= `SUPMON_MV_NONE;
            bat_first_thresh_mv  <= `SUPMON_MV_NONE;
            bat_second_thresh_mv <= `SUPMON_MV_NONE;
        end else begin
            brownout_thresh_mv   <= brownout_mv(brownout_level_sel_q);       // RULE_02
            bat_first_thresh_mv  <= bat_first_mv(battery_first_level_sel_q); // RULE_06
            bat_second_thresh_mv <= bat_second_mv(battery_second_level_sel_q); // RULE_07
        end
    end

    // ------------------------------------------------------------------------
    // Monitor flags
    // ------------------------------------------------------------------------
    // A status read counts only when the transfer closes with STOP
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_rd_q <= 1'b0;
        end else if (bus_stop || reg_wr) begin
            status_rd_q <= 1'b0;
        end else if (reg_rd && reg_addr == `SUPMON_ADDR_STATUS) begin
            status_rd_q <= 1'b1;
        end
    end

    assign auto_clear = bus_stop && status_rd_q && auto_clear_enable_q;      // RULE_16

    supmon_flag u_low_supply (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .raw_below  (supply_below),                                          // RULE_01
        .clear      (auto_clear || (wr_status && !reg_wdata[`SUPMON_STAT_LOW_SUPPLY])),
        .level_sync (supply_sync),
        .flag       (low_supply_flag)
    );

    supmon_flag u_bat_first (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .raw_below  (bat_first_below),                                       // RULE_14
        .clear      (auto_clear || (wr_status && !reg_wdata[`SUPMON_STAT_BAT_FIRST])),
        .level_sync (bat_first_sync),
        .flag       (battery_first_low_flag)
    );

    supmon_flag u_bat_second (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .raw_below  (bat_second_below),                                      // RULE_15
        .clear      (auto_clear || (wr_status && !reg_wdata[`SUPMON_STAT_BAT_SECOND])),
        .level_sync (bat_second_sync),
        .flag       (battery_second_low_flag)
    );

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= `SUPMON_RST_BYTE;
        end else if (reg_rd) begin
            rdata_q <= `SUPMON_RST_BYTE;
            unique case (reg_addr)
                `SUPMON_ADDR_STATUS: begin
                    rdata_q[`SUPMON_STAT_LOW_SUPPLY] <= low_supply_flag;
                    rdata_q[`SUPMON_STAT_BAT_FIRST]  <= battery_first_low_flag;
                    rdata_q[`SUPMON_STAT_BAT_SECOND] <= battery_second_low_flag;
                end
                `SUPMON_ADDR_CONTROL: rdata_q[`SUPMON_CTRL_AUTO_CLEAR] <= auto_clear_enable_q;
                `SUPMON_ADDR_BROWNOUT: rdata_q[2:0] <= brownout_level_sel_q;
                `SUPMON_ADDR_BATTERY: begin
                    rdata_q[`SUPMON_BAT_DISCONNECT]     <= battery_disconnect_q;
                    rdata_q[`SUPMON_BAT_FIRST_LSB+:3]  <= battery_first_level_sel_q;
                    rdata_q[`SUPMON_BAT_SECOND_LSB+:3] <= battery_second_level_sel_q;
                end
                `SUPMON_ADDR_TRIM: rdata_q <= trim_q;                        // RULE_08
                `SUPMON_ADDR_TEMPCTL: rdata_q[`SUPMON_TEMPCTL_SENSE] <= temp_sense_enable_q;
                default: rdata_q <= `SUPMON_RST_BYTE;
            endcase
        end
    end

    assign reg_rdata         = rdata_q;
    assign battery_isolate   = battery_disconnect_q;                          // RULE_04
    assign temp_sense_enable = temp_sense_enable_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_supply_sets;
        @(posedge mclk) disable iff (sys_rst)
        supply_below |-> ##3 low_supply_flag;
    endproperty
    a_supply_sets: assert property (p_supply_sets)                        // RULE_01
        else $error("low supply flag not set after sustained brownout");

    property p_brownout_top;
        @(posedge mclk) disable iff (sys_rst)
        (brownout_level_sel_q == 3'h5) [*2] |-> brownout_thresh_mv == `SUPMON_MV_4675;
    endproperty
    a_brownout_top: assert property (p_brownout_top)                      // RULE_02
        else $error("brownout code 5 not at top level");

    property p_battery_write;
        @(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == `SUPMON_ADDR_BATTERY ##1 !reg_wr
        ##1 reg_rd && reg_addr == `SUPMON_ADDR_BATTERY
        |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 3);
    endproperty
    a_battery_write: assert property (p_battery_write)                    // RULE_03
        else $error("battery selectors do not read back");

    property p_disconnect_set;
        @(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == `SUPMON_ADDR_BATTERY && reg_wdata[6] && !vdd_power_up
        |=> battery_isolate;
    endproperty
    a_disconnect_set: assert property (p_disconnect_set)                  // RULE_04
        else $error("disconnect write did not isolate battery");

    property p_reconnect;
        @(posedge mclk) disable iff (sys_rst)
        vdd_power_up |=> !battery_isolate;
    endproperty
    a_reconnect: assert property (p_reconnect)                            // RULE_05
        else $error("battery not reconnected after supply power-up");

    property p_first_levels;
        @(posedge mclk) disable iff (sys_rst)
        !$past(sys_rst) && $stable(battery_first_level_sel_q)
        && battery_first_level_sel_q == 3'h0
        |-> bat_first_thresh_mv == `SUPMON_MV_2125;
    endproperty
    a_first_levels: assert property (p_first_levels)                      // RULE_06
        else $error("first battery code 0 wrong level");

    property p_second_levels;
        @(posedge mclk) disable iff (sys_rst)
        $stable(battery_second_level_sel_q) && battery_second_level_sel_q == 3'h6
        |-> bat_second_thresh_mv == `SUPMON_MV_4125;
    endproperty
    a_second_levels: assert property (p_second_levels)                    // RULE_07
        else $error("second battery code 6 wrong level");

    property p_trim_ro;
        @(posedge mclk) disable iff (sys_rst)
        trim_loaded_q && reg_wr && reg_addr == `SUPMON_ADDR_TRIM |=> $stable(trim_q);
    endproperty
    a_trim_ro: assert property (p_trim_ro)                                // RULE_09
        else $error("trim changed on software write");

    property p_dtrim_plus;
        @(posedge mclk) disable iff (sys_rst)
        $stable(digital_trim_code) && digital_trim_code == 2'h1
        |-> pulse_insert_en && !pulse_skip_en && digital_trim_mode == DTRIM_PLUS;
    endproperty
    a_dtrim_plus: assert property (p_dtrim_plus)                          // RULE_11
        else $error("digital trim plus step decoded wrong");

    property p_atrim_step;
        @(posedge mclk) disable iff (sys_rst)
        $stable(analog_trim_code) && analog_trim_code == 6'h3f |-> analog_trim_ppm == -7'sd31;
    endproperty
    a_atrim_step: assert property (p_atrim_step)                          // RULE_13
        else $error("analog trim code 63 not at negative limit");

    property p_auto_clear;
        @(posedge mclk) disable iff (sys_rst)
        auto_clear && !supply_sync && !bat_first_sync && !bat_second_sync
        |=> !low_supply_flag && !battery_first_low_flag && !battery_second_low_flag;
    endproperty
    a_auto_clear: assert property (p_auto_clear)                          // RULE_16
        else $error("flags not cleared by status read with STOP");

    property p_sticky;
        @(posedge mclk) disable iff (sys_rst)
        low_supply_flag && !auto_clear && !wr_status |=> low_supply_flag;
    endproperty
    a_sticky: assert property (p_sticky)                                  // RULE_18
        else $error("low supply flag dropped without a clear");

endmodule : supmon_regs

// ---- supmon_regs_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module supmon_regs_tb;
    import supmon_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, bus_stop = 1'b0;
    logic vdd_power_up = 1'b0, supply_below = 1'b0;
    logic bat_first_below = 1'b0, bat_second_below = 1'b0;
    logic [7:0] reg_addr = 8'h00, factory_trim = 8'h00;
    supmon_byte_type reg_wdata = 8'h00, reg_rdata;
    logic [12:0] brownout_thresh_mv, bat_first_thresh_mv, bat_second_thresh_mv;
    logic battery_isolate, low_supply_flag, battery_first_low_flag, battery_second_low_flag;
    logic temp_sense_enable, pulse_insert_en, pulse_skip_en;
    supmon_dtrim_type digital_trim_mode;
    logic [5:0] load_cap_code;
    logic signed [6:0] analog_trim_ppm;
    logic smp = 1'b0, rdq = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [15:0] act, e, expq[$];
    int miscompares = 0, checked = 0;
    localparam logic [15:0] BO [8] = '{2295, 2550, 2805, 3060, 4250, 4675, 0, 0};
    localparam logic [15:0] B1 [8] = '{2125, 2295, 2550, 2805, 3060, 4250, 4675, 0};
    localparam logic [15:0] B2 [8] = '{1875, 2025, 2250, 2475, 2700, 3750, 4125, 0};

    supmon_regs i_supmon_regs (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .bus_stop, .reg_rdata, .factory_trim, .vdd_power_up, .supply_below,
        .bat_first_below, .bat_second_below, .brownout_thresh_mv, .bat_first_thresh_mv,
        .bat_second_thresh_mv, .battery_isolate, .low_supply_flag, .battery_first_low_flag,
        .battery_second_low_flag, .temp_sense_enable, .digital_trim_mode, .pulse_insert_en,
        .pulse_skip_en, .load_cap_code, .analog_trim_ppm);

    always #25 mclk = ~mclk;

    always_comb begin
        case (sel)
            3'h0: act = 16'(brownout_thresh_mv);
            3'h1: act = 16'(bat_first_thresh_mv);
            3'h2: act = 16'(bat_second_thresh_mv);
            3'h3: act = 16'({battery_isolate, low_supply_flag, battery_first_low_flag,
                             battery_second_low_flag});
            3'h4: act = 16'({digital_trim_mode, pulse_insert_en, pulse_skip_en, load_cap_code});
            3'h6: act = 16'(temp_sense_enable);
            default: act = {9'h000, analog_trim_ppm};
        endcase
    end

    // ------------------------------------------------------------------
    // Monitor: oldest note is matched against the result on show
    // ------------------------------------------------------------------
    always @(posedge mclk) rdq <= reg_rd;
    always @(negedge mclk) begin
        if (rdq || smp) begin
            e = expq.pop_front();
            `CHK((rdq ? 16'(reg_rdata) : act), e)
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // Idle cycle after each strobe so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        expq.push_back(16'(x));
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
    endtask : rd
    task automatic look(input logic [2:0] s, input logic [15:0] x);
        expq.push_back(x);
        sel <= s;
        smp <= 1'b1;
        tick(1);
        smp <= 1'b0;
        tick(1);
    endtask : look
    // Comparators high for one cycle only: flags must latch
    task automatic trip(input logic [2:0] v);
        {supply_below, bat_first_below, bat_second_below} <= v;
        tick(1);
        {supply_below, bat_first_below, bat_second_below} <= 3'b000;
        tick(6);
    endtask : trip
    task automatic finish_test;
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        #(4000 * 50);
        miscompares++;
        finish_test;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [2:0] v;
        void'($urandom(32'h048d));
        factory_trim = 8'($urandom);
        v = 3'($urandom_range(7, 1));
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        tick(3);
        rd(8'h0b, factory_trim);
        wr(8'h0b, ~factory_trim);
        rd(8'h0b, factory_trim);
        look(3'h4, 16'({factory_trim[7:6], factory_trim[7:6] == 2'b01,
            factory_trim[7:6] == 2'b11, factory_trim[5:0]}));
        look(3'h5, {9'h000, 7'h20 - {1'b0, factory_trim[5:0]}});
        rd(8'h1f, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(8'h09, 8'(i));
            look(3'h0, BO[i]);
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h0a, {2'b00, 3'(i), 3'(i)});
            rd(8'h0a, {2'b00, 3'(i), 3'(i)});
            look(3'h1, B1[i]);
            look(3'h2, B2[i]);
        end
        wr(8'h0a, 8'h40);
        look(3'h3, 16'h0008);
        vdd_power_up <= 1'b1;
        tick(1);
        vdd_power_up <= 1'b0;
        look(3'h3, 16'h0000);
        trip(v);
        look(3'h3, {13'h0000, v});
        rd(8'h07, {4'h0, v, 1'b0});
        wr(8'h07, 8'h00);
        look(3'h3, 16'h0000);
        trip(3'b111);
        wr(8'h08, 8'h80);
        rd(8'h07, 8'h0e);
        bus_stop <= 1'b1;
        tick(1);
        bus_stop <= 1'b0;
        look(3'h3, 16'h0000);
        wr(8'h0d, 8'h80);
        look(3'h6, 16'h0001);
        rd(8'h0d, 8'h80);
        factory_trim <= 8'h7f;
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(3);
        look(3'h6, 16'h0000);
        look(3'h4, 16'h01bf);
        look(3'h5, 16'h0061);
        finish_test;
    end
endmodule : supmon_regs_tb
